// file: kvm_select_pkg.sv
// shared constants and types for the channel select control
package kvm_select_pkg;
  // ---------------------------------------------------------------
  // sizes and reset values
  // ---------------------------------------------------------------
  localparam int NUM_HOSTS_DEF = 4;
  localparam int DATA_W = 8;
  localparam int CFG_W = 8;
  localparam logic [CFG_W-1:0] CFG_RST = 8'h00;
  localparam int SEL_RST = 0;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int AUTH_OFF_MS = 1000;
  // least time in whole cycles, at least one; CLK_HZ / 1000 truncates rather than rounding up
  localparam int AUTH_OFF_CYC = (AUTH_OFF_MS * (CLK_HZ / 1000) + 0) > 0 ?
                                AUTH_OFF_MS * (CLK_HZ / 1000) : 1;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic {
    METHOD_BUTTON = 1'b0,
    METHOD_REMOTE = 1'b1
  } method_t;

  // gray coded along run -> purge -> auth off; auth off -> run flips both bits
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_PURGE = 2'b01,
    ST_AUTH_OFF = 2'b11
  } state_t;

  typedef struct packed {
    logic vld;
    logic [DATA_W-1:0] data;
  } periph_word_t;
endpackage : kvm_select_pkg

// file: kvm_channel_select_control.sv
// channel selection, purge and one-way routing of keyboard and pointer data
`timescale 1ns/10ps
module kvm_channel_select_control #(
  parameter int NUM_HOSTS = kvm_select_pkg::NUM_HOSTS_DEF,
  parameter int AUTH_OFF_CYCLES = kvm_select_pkg::AUTH_OFF_CYC
) (
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // local switching controls
  input wire kvm_select_pkg::method_t METHOD,
  input wire logic [NUM_HOSTS-1:0] BTN,
  input wire logic RMT_VLD,
  input wire logic [7:0] RMT_IDX,
  // administrator configuration
  input wire logic ADMIN_MODE,
  input wire logic CFG_WR,
  input wire logic [kvm_select_pkg::CFG_W-1:0] CFG_DATA,
  // shared peripherals
  input wire kvm_select_pkg::periph_word_t KB_IN,
  input wire kvm_select_pkg::periph_word_t MS_IN,
  // host side control attempts, discarded on purpose
  input wire logic HOST_CMD_VLD,
  // host interfaces
  output kvm_select_pkg::periph_word_t [NUM_HOSTS-1:0] HOST_KB,
  output kvm_select_pkg::periph_word_t [NUM_HOSTS-1:0] HOST_MS,
  // status
  output logic [NUM_HOSTS-1:0] SEL_LED,
  output logic AUTH_PWR_EN,
  output logic SWITCHING,
  output logic [kvm_select_pkg::CFG_W-1:0] AUTH_FILTER_CFG
);
  import kvm_select_pkg::*;
  localparam int SEL_W = (NUM_HOSTS > 1) ? $clog2(NUM_HOSTS) : 1;
  localparam int CNT_W = $clog2(AUTH_OFF_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(AUTH_OFF_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(AUTH_OFF_CYCLES);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [NUM_HOSTS-1:0] idx2oh(input logic [SEL_W-1:0] i);
    logic [NUM_HOSTS-1:0] r;
    r = '0;
    r[i] = 1'b1;
    return r;
  endfunction : idx2oh
  function automatic logic is_oh(input logic [NUM_HOSTS-1:0] v);
    return (v != '0) && ((v & (v - 1'b1)) == '0);
  endfunction : is_oh
  function automatic logic [SEL_W-1:0] oh2idx(input logic [NUM_HOSTS-1:0] v);
    logic [SEL_W-1:0] r;
    r = '0;
    for (int k = 0; k < NUM_HOSTS; k++) begin
      if (v[k]) begin
        r = SEL_W'(k);
      end
    end
    return r;
  endfunction : oh2idx

  // ---------------------------------------------------------------
  // switch requests
  // ---------------------------------------------------------------
  logic [NUM_HOSTS-1:0] btn_prev_q, btn_prev_d;
  logic rmt_prev_q, rmt_prev_d;
  logic btn_req, rmt_req, req_ok, accept;
  logic [SEL_W-1:0] req_idx;
  state_t state_q, state_d;
  logic [SEL_W-1:0] sel_q, sel_d;
  // only a press from the all-released state counts, so a stuck button is one request
  always_comb begin
    btn_prev_d = BTN;
    rmt_prev_d = RMT_VLD;
    btn_req = (btn_prev_q == '0) && is_oh(BTN);
    rmt_req = RMT_VLD && !rmt_prev_q && (RMT_IDX < 8'(NUM_HOSTS));
    // the idle method is dropped outright; hosts have no request path at all
    if (METHOD == METHOD_BUTTON) begin
      req_ok = btn_req;
      req_idx = oh2idx(BTN);
    end else begin
      req_ok = rmt_req;
      req_idx = RMT_IDX[SEL_W-1:0];
    end
    accept = req_ok && (state_q == ST_RUN) && (req_idx != sel_q);
  end
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      btn_prev_q <= '1;
      rmt_prev_q <= 1'b1;
    end else begin
      btn_prev_q <= btn_prev_d;
      rmt_prev_q <= rmt_prev_d;
    end
  end

  // ---------------------------------------------------------------
  // selection, switch sequence and auth device power
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic pwr_q, pwr_d;
  logic [NUM_HOSTS-1:0] led_q, led_d;
  logic switching_q, switching_d;
  // a single selection feeds keyboard, pointer and indicator alike
  always_comb begin
    state_d = state_q;
    sel_d = sel_q;
    cnt_d = cnt_q;
    pwr_d = pwr_q;
    case (state_q)
      ST_RUN: begin
        if (accept) begin
          sel_d = req_idx;
          pwr_d = 1'b0;
          state_d = ST_PURGE;
        end
      end
      ST_PURGE: begin
        cnt_d = '0;
        state_d = ST_AUTH_OFF;
      end
      ST_AUTH_OFF: begin
        // off for the purge cycle plus the full count, never short
        if (cnt_q == CNT_LAST) begin
          pwr_d = 1'b1;
          state_d = ST_RUN;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
    led_d = idx2oh(sel_d);
    switching_d = (state_d != ST_RUN); // registered so the pin shows no decode glitch
  end
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      state_q <= ST_RUN;
      sel_q <= SEL_W'(SEL_RST);
      cnt_q <= '0;
      pwr_q <= 1'b1;
      led_q <= idx2oh(SEL_W'(SEL_RST));
      switching_q <= 1'b0;
    end else begin
      state_q <= state_d;
      sel_q <= sel_d;
      cnt_q <= cnt_d;
      pwr_q <= pwr_d;
      led_q <= led_d;
      switching_q <= switching_d;
    end
  end
  assign SEL_LED = led_q;
  assign AUTH_PWR_EN = pwr_q;
  assign SWITCHING = switching_q;

  // ---------------------------------------------------------------
  // one-way routing to the selected host
  // ---------------------------------------------------------------
  periph_word_t [NUM_HOSTS-1:0] kb_q, kb_d, ms_q, ms_d;
  logic fwd;
  // every host word is zero unless selected; plain flops, so nothing survives power loss
  always_comb begin
    fwd = (state_q == ST_RUN) && !accept;
    for (int h = 0; h < NUM_HOSTS; h++) begin
      kb_d[h] = '0;
      ms_d[h] = '0;
      if (fwd && (SEL_W'(h) == sel_q)) begin
        kb_d[h] = KB_IN;
        ms_d[h] = MS_IN;
      end
    end
  end
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      kb_q <= '0;
      ms_q <= '0;
    end else begin
      kb_q <= kb_d;
      ms_q <= ms_d;
    end
  end
  assign HOST_KB = kb_q;
  assign HOST_MS = ms_q;

  // ---------------------------------------------------------------
  // auth device filter configuration
  // ---------------------------------------------------------------
  logic [CFG_W-1:0] cfg_q, cfg_d;
  // user-mode writes are dropped silently
  always_comb begin
    cfg_d = cfg_q;
    if (CFG_WR && ADMIN_MODE) begin
      cfg_d = CFG_DATA;
    end
  end
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      cfg_q <= CFG_RST;
    end else begin
      cfg_q <= cfg_d;
    end
  end
  assign AUTH_FILTER_CFG = cfg_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [NUM_HOSTS-1:0] kb_vld_v, ms_vld_v;
  logic [CNT_W-1:0] off_len_q, off_len_d;
  // off-time meter seen only by the checks
  always_comb begin
    for (int h = 0; h < NUM_HOSTS; h++) begin
      kb_vld_v[h] = kb_q[h].vld;
      ms_vld_v[h] = ms_q[h].vld;
    end
    off_len_d = '0;
    if (!pwr_q) begin
      off_len_d = (off_len_q == CNT_FULL) ? off_len_q : off_len_q + 1'b1;
    end
  end
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      off_len_q <= '0;
    end else begin
      off_len_q <= off_len_d;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  sequence s_switch;
    accept ##1 (state_q == ST_PURGE);
  endsequence
  sequence s_quiet;
    (kb_vld_v == '0) [*2];
  endsequence
  property p_only_sel;
    (kb_vld_v & ~idx2oh(sel_q)) == '0;
  endproperty
  a_only_sel: assert property (p_only_sel) else $error("keyboard word at unselected host");
  property p_purge;
    s_switch |-> s_quiet;
  endproperty
  a_purge: assert property (p_purge) else $error("keyboard word during switch purge");
  property p_pwr_off;
    accept |=> !AUTH_PWR_EN [*8];
  endproperty
  a_pwr_off: assert property (p_pwr_off) else $error("auth power not removed on switch");
  // a reset in mid-switch restores power at once, so the first cycle after it is left out
  property p_pwr_len;
    $rose(AUTH_PWR_EN) && $past(NRST) |-> (off_len_q == CNT_FULL);
  endproperty
  a_pwr_len: assert property (p_pwr_len) else $error("auth power back too early");
  property p_one_method;
    (METHOD == METHOD_REMOTE) && !rmt_req |=> $stable(sel_q);
  endproperty
  a_one_method: assert property (p_one_method) else $error("selection moved by idle method");
  property p_led;
    SEL_LED == idx2oh(sel_q);
  endproperty
  a_led: assert property (p_led) else $error("indicator differs from selection");
  property p_tied;
    (ms_vld_v & ~SEL_LED) == '0;
  endproperty
  a_tied: assert property (p_tied) else $error("pointer routed apart from keyboard");
  property p_admin;
    CFG_WR && !ADMIN_MODE |=> $stable(AUTH_FILTER_CFG);
  endproperty
  a_admin: assert property (p_admin) else $error("user changed filter configuration");
  property p_admin_wr;
    CFG_WR && ADMIN_MODE |=> AUTH_FILTER_CFG == $past(CFG_DATA);
  endproperty
  a_admin_wr: assert property (p_admin_wr) else $error("administrator write lost");
  property p_stuck;
    (METHOD == METHOD_BUTTON) && $stable(BTN) && (BTN != '0) |=> $stable(sel_q);
  endproperty
  a_stuck: assert property (p_stuck) else $error("held button switched again");
  property p_host_cmd;
    HOST_CMD_VLD && !req_ok |=> $stable(sel_q);
  endproperty
  a_host_cmd: assert property (p_host_cmd) else $error("host command changed selection");
endmodule : kvm_channel_select_control

// file: kvm_periph_model.sv
// peripheral model: keyboard and pointer word source for the switch
`timescale 1ns/10ps
module kvm_periph_model (
  // clock
  input wire logic clk,
  // traffic enable
  input wire logic en,
  // words toward the switch
  output kvm_select_pkg::periph_word_t kb,
  output kvm_select_pkg::periph_word_t ms
);
  import kvm_select_pkg::*;
  // start quiet so the switch sees no word at time zero
  initial begin
    kb = '0;
    ms = '0;
  end
  // idle words flip their byte so a stale byte never looks fresh
  always @(posedge clk) begin
    kb <= '{vld: en && $urandom_range(3, 0) != 0, data: en ? 8'($urandom) : ~kb.data};
    ms <= '{vld: en && $urandom_range(3, 0) != 0, data: en ? 8'($urandom) : ~ms.data};
  end
endmodule : kvm_periph_model

// file: kvm_channel_select_control_tb_top.sv
// self-checking bench for the channel select control
`timescale 1ns/10ps
module kvm_channel_select_control_tb_top;
  import kvm_select_pkg::*;
  localparam int N = 4;
  localparam int OFF = 20;
  logic CLK = 0, NRST = 0, RMT_VLD = 0, ADMIN_MODE = 0, CFG_WR = 0, HOST_CMD_VLD = 0, en = 0;
  method_t METHOD = METHOD_BUTTON;
  logic [N-1:0] BTN = '0;
  logic [N-1:0] SEL_LED;
  logic [7:0] RMT_IDX = '0;
  logic [CFG_W-1:0] CFG_DATA = '0;
  logic [CFG_W-1:0] AUTH_FILTER_CFG;
  logic [CFG_W-1:0] cfg_m = '0;
  periph_word_t KB_IN, MS_IN;
  periph_word_t [N-1:0] HOST_KB, HOST_MS;
  logic AUTH_PWR_EN, SWITCHING;
  int n_fail = 0, checks_done = 0, sel_m = 0;

  // ---------------------------------------------------------------
  // clock, peers and watchdog
  // ---------------------------------------------------------------
  always #20 CLK = ~CLK;
  kvm_periph_model PEER (.clk(CLK), .en(en), .kb(KB_IN), .ms(MS_IN));
  kvm_channel_select_control #(.NUM_HOSTS(N), .AUTH_OFF_CYCLES(OFF)) DUT (
    .CLK(CLK), .NRST(NRST), .METHOD(METHOD), .BTN(BTN), .RMT_VLD(RMT_VLD), .RMT_IDX(RMT_IDX),
    .ADMIN_MODE(ADMIN_MODE), .CFG_WR(CFG_WR), .CFG_DATA(CFG_DATA), .KB_IN(KB_IN), .MS_IN(MS_IN),
    .HOST_CMD_VLD(HOST_CMD_VLD), .HOST_KB(HOST_KB), .HOST_MS(HOST_MS), .SEL_LED(SEL_LED),
    .AUTH_PWR_EN(AUTH_PWR_EN), .SWITCHING(SWITCHING), .AUTH_FILTER_CFG(AUTH_FILTER_CFG));
  // the whole run is under a thousand cycles; this bound of 10000 is generous
  initial begin
    #(40 * 10000);
    n_fail++;
    finish_test();
  end

  // ---------------------------------------------------------------
  // checking helpers
  // ---------------------------------------------------------------
  task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  task endt(input string s);
    $display("test %s done", s);
  endtask : endt
  // host vector with the word only at the selected host
  function automatic logic [N*9-1:0] route(periph_word_t w);
    logic [N*9-1:0] r;
    r = '0;
    r[sel_m*9 +: 9] = w;
    return r;
  endfunction : route
  // whether a request must be taken, and its target host
  function automatic bit exp_ok(bit m, logic [N-1:0] b, logic [7:0] idx, output int t);
    t = m ? int'(idx) : -1;
    if (!m) for (int i = 0; i < N; i++) if (b == 1 << i) t = i;
    return m == METHOD && t >= 0 && t < N && t != sel_m;
  endfunction : exp_ok

  // ---------------------------------------------------------------
  // stimulus tasks
  // ---------------------------------------------------------------
  // steady routing while hosts try to take control
  task idle_chk(input int n);
    periph_word_t kb, ms;
    repeat (n) begin
      @(posedge CLK);
      kb = KB_IN;
      ms = MS_IN;
      HOST_CMD_VLD <= 1'($urandom);
      #1;
      chk("host_kb", HOST_KB, route(kb));
      chk("host_ms", HOST_MS, route(ms));
      chk("sel_led", SEL_LED, 1 << sel_m);
    end
  endtask : idle_chk
  // one request; hold leaves the input asserted, else an intruder hits mid-switch
  task sw(input bit m, input logic [N-1:0] b, input logic [7:0] idx, input bit hold);
    int t, cnt;
    bit ok;
    @(posedge CLK);
    ok = exp_ok(m, b, idx, t);
    BTN <= '0;
    RMT_VLD <= 1'b0;
    @(posedge CLK);
    if (m) begin
      RMT_VLD <= 1'b1;
      RMT_IDX <= idx;
    end else BTN <= b;
    @(posedge CLK);
    if (!hold) begin
      BTN <= '0;
      RMT_VLD <= 1'b0;
    end
    #1;
    if (ok) sel_m = t;
    chk("sel_led", SEL_LED, 1 << sel_m);
    chk("switching", SWITCHING, ok);
    cnt = 0;
    while (ok && AUTH_PWR_EN === 1'b0 && cnt < OFF + 5) begin
      cnt++;
      chk("purge", HOST_KB | HOST_MS, 0);
      @(posedge CLK);
      BTN <= (cnt == 3 && !hold) ? N'(1 << ((t + 1) % N)) : BTN;
      RMT_VLD <= hold ? RMT_VLD : cnt == 3;
      RMT_IDX <= 8'((t + 1) % N);
      #1;
    end
    if (ok) chk("auth_off", cnt, OFF + 1);
    chk("sel_after", SEL_LED, 1 << sel_m);
    chk("switch_end", SWITCHING, 0);
  endtask : sw
  task cfg(input bit adm, input logic [7:0] d);
    @(posedge CLK);
    ADMIN_MODE <= adm;
    CFG_WR <= 1'b1;
    CFG_DATA <= d;
    @(posedge CLK);
    CFG_WR <= 1'b0;
    #1;
    if (adm) cfg_m = d;
    chk("cfg", AUTH_FILTER_CFG, cfg_m);
  endtask : cfg
  task rst_chk;
    chk("rst_led", SEL_LED, 1);
    chk("rst_auth", AUTH_PWR_EN, 1);
    chk("rst_cfg", AUTH_FILTER_CFG, 0);
  endtask : rst_chk

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(12));
    repeat (16) @(posedge CLK);
    rst_chk();
    NRST <= 1'b1;
    en <= 1'b1;
    idle_chk(30);
    endt("routing");
    sw(0, 4'b0011, 0, 0);
    sw(0, 4'b0001, 0, 0);
    sw(1, 0, 8'd2, 0);
    sw(0, 4'b0100, 0, 1);
    idle_chk(10);
    @(posedge CLK);
    BTN <= '0;
    endt("buttons");
    METHOD <= METHOD_REMOTE;
    sw(1, 0, 8'd4, 0);
    sw(1, 0, 8'hff, 0);
    sw(0, 4'b0010, 0, 0);
    for (int h = 0; h < N; h++) sw(1, 0, 8'(h), 0);
    sw(1, 0, 8'd1, 1);
    idle_chk(10);
    endt("remote");
    repeat (12) begin
      @(posedge CLK);
      METHOD <= method_t'(1'($urandom));
      sw(1'($urandom), 4'($urandom), 8'($urandom_range(5, 0)), 0);
      idle_chk(5);
    end
    endt("random");
    cfg(0, 8'h5a);
    cfg(1, 8'ha5);
    cfg(1, 8'($urandom));
    cfg(0, 8'h00);
    endt("config");
    @(posedge CLK);
    NRST <= 1'b0;
    @(posedge CLK);
    NRST <= 1'b1;
    METHOD <= METHOD_BUTTON;
    #1;
    rst_chk();
    sel_m = 0;
    cfg_m = '0;
    sw(0, 4'b1000, 0, 0);
    idle_chk(5);
    endt("rereset");
    finish_test();
  end
endmodule : kvm_channel_select_control_tb_top
